// ===== rtl/psm_header.sv
/*
 * Receive side of the secure paging message header: checksum check,
 * fragment and message number tracking, character unpacking.
 * Assumes word_valid pulses come from logic on clk_sys; fragment
 * boundaries are marked by frag_start on the first header word.
 */
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Checksum sum clears at fragment start, adds every word including last.
// - Each word adds as three groups: bits 0-7, 8-15, 16-20.
// - Check value is inverted sum, low ten bits, in first word.
// - Continuation flag set means more fragments; clear marks final fragment.
// - First fragment number is 11, then increments modulo 3.
// - After start, 11 never recurs; later fragments cycle 00,01,10.
// - Message number wrap limit comes from a software register.
// - Unexpected message number raises missed flag and reports skipped number.
// - Messages with retrieval flag zero leave number tracking untouched.
// - Message number ties fragments of one message together.
// - Text starts at first character of second word of fragment.
module psm_header
	import psm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic word_valid,
	input wire logic [WORD_W-1:0] word_data,
	input wire logic frag_start,
	input wire logic frag_end,
	input wire logic retrieval_flag,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic char_valid,
	output logic [CHAR_W-1:0] char_data,
	output logic char_first,
	output logic frag_done,
	output logic frag_chk_err,
	output logic frag_more,
	output logic [1:0] frag_num,
	output logic [NUM_W-1:0] msg_num,
	output logic missed
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	psm_state_e state;
	logic [SUM_W-1:0] sum, next_sum;
	logic [CHK_W-1:0] rx_chk, calc_chk;
	logic [6:0] wcnt;
	logic [NUM_W-1:0] num_limit, expect_num, hdr_num, missed_num, next_expect;
	logic [1:0] hdr_frag, expect_frag, pend_idx;
	logic [7:0] err_cnt;
	logic [WORD_W-1:0] sum_word;
	logic [CHARS_PER_WORD*CHAR_W-1:0] chars, pend_chars;
	logic [CHARS_PER_WORD-1:0] is_fill, pend_fill;
	logic enable, expect_ok, hdr_cont, hdr_retr, in_msg, seq_err, pend_first;
	logic clr_missed, clr_seq, clr_err, acc, is_hdr, ack;

	assign acc = clk_en && word_valid;
	assign is_hdr = acc && frag_start;

	// ---------------------------------------------------------------
	// Character slicer
	// ---------------------------------------------------------------
	psm_char_unpack u_unpack (
		.word(word_data),
		.chars(chars),
		.is_fill(is_fill)
	);

	// ---------------------------------------------------------------
	// Checksum
	// ---------------------------------------------------------------
	// check field counts as zero, as the sender summed it
	assign sum_word = frag_start ?
		{word_data[WORD_W-1:CHK_W], {CHK_W{1'b0}}} : word_data;

	always_comb begin
		next_sum = (frag_start ? SUM_ZERO : sum)
			+ SUM_W'(sum_word[GRP0_LSB +: GRP0_W])
			+ SUM_W'(sum_word[GRP1_LSB +: GRP1_W])
			+ SUM_W'(sum_word[GRP2_LSB +: GRP2_W]);
	end

	assign calc_chk = ~next_sum[CHK_W-1:0];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sum <= SUM_ZERO;
		end else if (acc) begin
			sum <= next_sum;
		end
	end

	// ---------------------------------------------------------------
	// Fragment state machine
	// ---------------------------------------------------------------
	// Word count guards against runaway fragments past the frame limit
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= PSM_IDLE;
			wcnt <= '0;
			rx_chk <= '0;
		end else if (clk_en) begin
			case (state)
				PSM_IDLE: begin
					if (is_hdr && enable) begin
						rx_chk <= word_data[CHK_LSB +: CHK_W];
						wcnt <= WCNT_ONE;
						state <= frag_end ? PSM_END : PSM_BODY;
					end
				end
				PSM_BODY: begin
					if (acc) begin
						wcnt <= wcnt + WCNT_ONE;
						if (frag_end || wcnt == 7'(MAX_WORDS - 1)) begin
							state <= PSM_END;
						end
					end
				end
				PSM_END: begin
					state <= PSM_IDLE;
				end
				default: begin
					state <= PSM_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Fragment result outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			frag_done <= 1'b0;
			frag_chk_err <= 1'b0;
		end else if (clk_en) begin
			frag_done <= 1'b0;
			if (state != PSM_IDLE && acc && (frag_end || wcnt == 7'(MAX_WORDS - 1))) begin
				frag_done <= 1'b1;
				frag_chk_err <= (calc_chk != rx_chk);
			end else if (state == PSM_IDLE && is_hdr && enable && frag_end) begin
				frag_done <= 1'b1;
				frag_chk_err <= (calc_chk != word_data[CHK_LSB +: CHK_W]);
			end
		end
	end

	// ---------------------------------------------------------------
	// Header fields
	// ---------------------------------------------------------------
	// spare bits ignored
	assign hdr_cont = word_data[CONT_BIT];
	assign hdr_frag = word_data[FRAG_LSB +: 2];
	assign hdr_num = word_data[NUM_LSB +: NUM_W];
	assign hdr_retr = retrieval_flag;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			frag_more <= 1'b0;
			frag_num <= 2'h0;
			msg_num <= '0;
			in_msg <= 1'b0;
			expect_frag <= FRAG_START;
		end else if (clk_en && is_hdr && enable) begin
			frag_more <= hdr_cont;
			frag_num <= hdr_frag;
			msg_num <= hdr_num;
			in_msg <= hdr_cont;
			if (hdr_frag == 2'h2 || hdr_frag == FRAG_START) begin
				expect_frag <= 2'h0;
			end else begin
				expect_frag <= hdr_frag + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			seq_err <= 1'b0;
		end else if (clk_en) begin
			if (is_hdr && enable && in_msg && hdr_frag != FRAG_START &&
				(hdr_frag != expect_frag || hdr_num != msg_num)) begin
				seq_err <= 1'b1;
			end else if (clr_seq) begin
				seq_err <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Missed message tracking
	// ---------------------------------------------------------------
	// configurable wrap
	assign next_expect = (hdr_num >= num_limit) ? '0 : hdr_num + 6'h01;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			expect_num <= '0;
			expect_ok <= 1'b0;
			missed <= 1'b0;
			missed_num <= '0;
		end else if (clk_en) begin
			if (is_hdr && enable && hdr_retr && hdr_frag == FRAG_START) begin
				if (expect_ok && hdr_num != expect_num) begin
					missed <= 1'b1;
					missed_num <= expect_num;
				end else if (clr_missed) begin
					missed <= 1'b0;
				end
				expect_num <= next_expect;
				expect_ok <= 1'b1;
			end else if (clr_missed) begin
				missed <= 1'b0;
			end
			if (clr_seq) begin
				expect_ok <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Character output
	// ---------------------------------------------------------------
	// text after header
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pend_chars <= '0;
			pend_fill <= '1;
			pend_idx <= 2'h0;
			pend_first <= 1'b0;
			char_valid <= 1'b0;
			char_data <= '0;
			char_first <= 1'b0;
		end else if (clk_en) begin
			char_valid <= 1'b0;
			if (acc && !frag_start && state == PSM_BODY) begin
				pend_chars <= chars;
				pend_fill <= is_fill;
				pend_idx <= 2'h0;
				pend_first <= (wcnt == WCNT_ONE);
			end else if (pend_idx != 2'(CHARS_PER_WORD)) begin
				pend_idx <= pend_idx + 2'h1;
				if (!pend_fill[pend_idx]) begin
					char_valid <= 1'b1;
					char_data <= pend_chars[pend_idx*CHAR_W +: CHAR_W];
					char_first <= pend_first;
					pend_first <= 1'b0;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Avalon-MM slave, one wait cycle per access
	// ---------------------------------------------------------------
	// Wait flag is the flop itself, so the bus sees no logic behind it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
		end else if (clk_en) begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end
	assign ack = !avs_waitrequest;

	assign clr_missed = ack && avs_write && avs_address == REG_STATUS &&
		avs_writedata[ST_MISSED];
	assign clr_seq = ack && avs_write && avs_address == REG_CTRL &&
		avs_writedata[CTRL_RESYNC];
	assign clr_err = ack && avs_write && avs_address == REG_STATUS &&
		avs_writedata[ST_CHK_ERR];

	// Software settings
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enable <= 1'b0;
			num_limit <= NUM_LIMIT_RST;
		end else if (clk_en && ack && avs_write) begin
			if (avs_address == REG_CTRL) begin
				enable <= avs_writedata[CTRL_ENABLE];
			end
			if (avs_address == REG_LIMIT) begin
				num_limit <= avs_writedata[NUM_W-1:0];
			end
		end
	end

	// Sticky error counter; a new error wins over a clear
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			err_cnt <= '0;
		end else if (clk_en) begin
			if (frag_done && frag_chk_err) begin
				err_cnt <= err_cnt + CNT_ONE;
			end else if (clr_err) begin
				err_cnt <= '0;
			end
		end
	end

	// Read data mux
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			avs_readdata <= RD_UNMAPPED;
		end else if (clk_en) begin
			avs_readdata <= RD_UNMAPPED;
			if (avs_read && !ack) begin
				case (avs_address)
					REG_CTRL: avs_readdata <= {30'h0, 1'b0, enable};
					REG_STATUS: avs_readdata <= {16'h0, err_cnt, 3'h0,
						frag_more, frag_done, seq_err, missed, frag_chk_err};
					REG_HEADER: avs_readdata <= {23'h0, msg_num, frag_num, frag_more};
					REG_MISSED: avs_readdata <= {20'h0, expect_num, missed_num};
					REG_LIMIT: avs_readdata <= {26'h0, num_limit};
					default: avs_readdata <= RD_UNMAPPED;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_hdr_start;
		is_hdr && enable && hdr_retr && hdr_frag == FRAG_START && expect_ok &&
			hdr_num != expect_num;
	endsequence
	chk_missed_raise: assert property (@(posedge clk_sys) disable iff (reset)
		s_hdr_start |=> missed) else $error("missed flag not raised");
	chk_unnum_keep: assert property (@(posedge clk_sys) disable iff (reset)
		(is_hdr && !hdr_retr && !clr_seq) |=> $stable(expect_num))
		else $error("unnumbered message moved expected number");
	chk_wait_one: assert property (@(posedge clk_sys) disable iff (reset)
		(clk_en && avs_write && !ack) |=> !avs_waitrequest) else $error("bus wait too long");
	chk_frag_step: assert property (@(posedge clk_sys) disable iff (reset)
		expect_frag != FRAG_START || !in_msg) else $error("start code expected mid message");
	chk_fill_drop: assert property (@(posedge clk_sys) disable iff (reset)
		char_valid |-> char_data != CHAR_ETX) else $error("fill character reported");
	chk_done_pulse: assert property (@(posedge clk_sys) disable iff (reset)
		(state == PSM_BODY && acc && frag_end) |=> frag_done) else $error("no result");
	chk_frag_wrap: assert property (@(posedge clk_sys) disable iff (reset)
		(is_hdr && enable) |=> expect_frag != FRAG_START) else $error("start code next");
endmodule : psm_header

// ===== rtl/psm_pkg.sv
/*
 * Shared constants for the secure paging message header block.
 * Assumes 21-bit information words, already error corrected upstream.
 */
package psm_pkg;
	// ---------------------------------------------------------------
	// Word layout
	// ---------------------------------------------------------------
	localparam int WORD_W = 21;
	localparam int CHK_W = 10;
	localparam int SUM_W = 16;
	localparam int CHAR_W = 7;
	localparam int NUM_W = 6;
	localparam int CHK_LSB = 0;
	localparam int CONT_BIT = 10;
	localparam int FRAG_LSB = 11;
	localparam int NUM_LSB = 13;
	localparam int GRP0_LSB = 0;
	localparam int GRP1_LSB = 8;
	localparam int GRP2_LSB = 16;
	localparam int GRP0_W = 8;
	localparam int GRP1_W = 8;
	localparam int GRP2_W = 5;
	localparam int CHARS_PER_WORD = 3;
	localparam int MAX_WORDS = 84;
	localparam logic [1:0] FRAG_START = 2'h3;
	localparam logic [6:0] CHAR_ETX = 7'h03;
	localparam logic [5:0] NUM_LIMIT_RST = 6'h3F;
	// ---------------------------------------------------------------
	// Register map (word addresses, byte address = 4 * index)
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_HEADER = 4'h2;
	localparam logic [3:0] REG_MISSED = 4'h3;
	localparam logic [3:0] REG_LIMIT = 4'h4;
	localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
	// Control bits
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_RESYNC = 1;
	// Status bits
	localparam int ST_CHK_ERR = 0;
	localparam int ST_MISSED = 1;
	localparam int ST_SEQ_ERR = 2;
	localparam int ST_DONE = 3;
	localparam int ST_LAST = 4;
	localparam int ST_CHK_ERR_CNT_LSB = 8;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [SUM_W-1:0] SUM_ZERO = 16'h0000;
	localparam logic [6:0] WCNT_ONE = 7'h01;

	typedef enum logic [2:0] {
		PSM_IDLE = 3'b001,
		PSM_BODY = 3'b010,
		PSM_END = 3'b100
	} psm_state_e;
endpackage : psm_pkg

// ===== rtl/psm_char_unpack.sv
/*
 * Splits one content word into three 7-bit characters with fill flags.
 * Assumes a word from the same clock domain; purely combinational.
 */
`timescale 1ns/1ps
module psm_char_unpack
	import psm_pkg::*;
(
	input wire logic [WORD_W-1:0] word,
	output logic [CHARS_PER_WORD*CHAR_W-1:0] chars,
	output logic [CHARS_PER_WORD-1:0] is_fill
);
	// ---------------------------------------------------------------
	// Per-character slicing
	// ---------------------------------------------------------------
	for (genvar g = 0; g < CHARS_PER_WORD; g++) begin : g_char
		assign chars[g*CHAR_W +: CHAR_W] = word[g*CHAR_W +: CHAR_W];
		assign is_fill[g] = (word[g*CHAR_W +: CHAR_W] == CHAR_ETX);
	end
endmodule : psm_char_unpack

// ===== testbench/psm_encoder_model.sv
/*
 * Encoder model: builds one fragment of a secure message and sends it
 * word by word. Assumes the bench calls send() and owns clk_sys.
 */
`timescale 1ns/1ps
module psm_encoder_model
	import psm_pkg::*;
(
	input wire logic clk_sys,
	output logic word_valid,
	output logic [WORD_W-1:0] word_data,
	output logic frag_start,
	output logic frag_end,
	output logic retrieval_flag
);
	// Characters the receiver should report, in order
	logic [6:0] exp_q[$];

	initial begin
		word_valid = 1'b0;
		word_data = '0;
		frag_start = 1'b0;
		frag_end = 1'b0;
		retrieval_flag = 1'b0;
	end

	// One word, then idle; idle data is inverted so it never looks held
	task automatic put(input logic [WORD_W-1:0] w, input logic s, input logic e, input logic r);
		@(posedge clk_sys);
		word_valid <= 1'b1;
		word_data <= w;
		frag_start <= s;
		frag_end <= e;
		retrieval_flag <= r;
		@(posedge clk_sys);
		word_valid <= 1'b0;
		word_data <= ~w;
		frag_start <= 1'b0;
		frag_end <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : put

	task automatic send(input logic [5:0] num, input logic more, input logic [1:0] fn,
		input logic rf, input int nch, input logic bad);
		logic [WORD_W-1:0] w[$];
		logic [WORD_W-1:0] cw;
		logic [6:0] c;
		logic [SUM_W-1:0] sum;
		int nw;
		nw = (nch + 2) / 3;
		if (nw > MAX_WORDS - 1) begin
			nw = MAX_WORDS - 1;
		end
		w.push_back({2'b00, num, fn, more, 10'h000});
		// text from word two, ETX fill
		for (int i = 0; i < nw; i++) begin
			cw = '0;
			for (int k = 0; k < 3; k++) begin
				c = (3 * i + k < nch) ? 7'($urandom_range(32, 126)) : CHAR_ETX;
				if (c != CHAR_ETX) begin
					exp_q.push_back(c);
				end
				cw[7 * k +: 7] = c;
			end
			w.push_back(cw);
		end
		sum = SUM_ZERO;
		foreach (w[j]) begin
			sum += w[j][7:0] + w[j][15:8] + w[j][20:16];
		end
		w[0] = {w[0][20:10], ~sum[9:0] ^ {9'h000, bad}};
		foreach (w[j]) begin
			put(w[j], j == 0, j == w.size() - 1, rf);
		end
	endtask : send
endmodule : psm_encoder_model

// ===== testbench/psm_header_bench.sv
/*
 * Self-checking bench for the message header block.
 * Assumes psm_pkg, the design and the encoder model are compiled first.
 */
`timescale 1ns/1ps
module psm_header_bench
	import psm_pkg::*;
;
	logic clk_sys, reset, clk_en, avs_read, avs_write, avs_waitrequest;
	logic word_valid, frag_start, frag_end, retrieval_flag;
	logic char_valid, char_first, frag_done, frag_chk_err, frag_more, missed;
	logic [WORD_W-1:0] word_data;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [CHAR_W-1:0] char_data;
	logic [1:0] frag_num;
	logic [NUM_W-1:0] msg_num;
	logic [9:0] d_hdr;
	logic [7:0] got_q[$];
	int error_cnt, checks, d_cnt, d_frz;

	psm_header dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.word_valid(word_valid), .word_data(word_data), .frag_start(frag_start),
		.frag_end(frag_end), .retrieval_flag(retrieval_flag), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.char_valid(char_valid), .char_data(char_data), .char_first(char_first),
		.frag_done(frag_done), .frag_chk_err(frag_chk_err), .frag_more(frag_more),
		.frag_num(frag_num), .msg_num(msg_num), .missed(missed));

	psm_encoder_model enc (.clk_sys(clk_sys), .word_valid(word_valid),
		.word_data(word_data), .frag_start(frag_start), .frag_end(frag_end),
		.retrieval_flag(retrieval_flag));

	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Collect characters and fragment results as they stand
	always @(posedge clk_sys) begin
		if (char_valid === 1'b1) begin
			got_q.push_back({char_first, char_data});
		end
		if (frag_done === 1'b1) begin
			d_cnt++;
			d_hdr = {frag_chk_err, frag_more, frag_num, msg_num};
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Avalon access: hold until waitrequest is seen low at an edge
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			error_cnt++;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : av

	task automatic frag(input logic [5:0] num, input logic more, input logic [1:0] fn,
		input logic rf, input int nch, input logic bad);
		int n0;
		n0 = d_cnt;
		enc.send(num, more, fn, rf, nch, bad);
		for (int i = 0; i < 20 && d_cnt == n0; i++) begin
			@(posedge clk_sys);
		end
		// Let the last word's characters drain into the queue
		repeat (2) @(posedge clk_sys);
		chk(32'(d_cnt - n0), 32'h1);
		chk(32'(d_hdr), 32'({bad, more, fn, num}));
		chk(32'(got_q.size()), 32'(enc.exp_q.size()));
		foreach (enc.exp_q[i]) chk(32'(got_q[i]), 32'({i == 0, enc.exp_q[i]}));
		got_q.delete();
		enc.exp_q.delete();
	endtask : frag

	task automatic tally_and_finish();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// Watchdog, far beyond the expected run length
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h86926764));
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		clk_en = 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		av(1'b0, REG_LIMIT, 32'h0);
		chk(rd, 32'h3F);
		av(1'b0, 4'hF, 32'h0);
		chk(rd, RD_UNMAPPED);
		av(1'b1, REG_CTRL, 32'h1);
		frag(6'h00, 1'b0, FRAG_START, 1'b1, 1, 1'b0);
		frag(6'h28, 1'b0, FRAG_START, 1'b0, 20, 1'b1);
		av(1'b0, REG_STATUS, 32'h0);
		chk(32'(rd[15:8]), 32'h1);
		// Start fragment, then numbers must cycle 00, 01, 10, 00
		frag(6'h01, 1'b1, FRAG_START, 1'b1, 1 + $urandom_range(0, 40), 1'b0);
		for (int i = 0; i < 4; i++) begin
			frag(6'h01, i < 3, 2'(i % 3), 1'b1, 1 + $urandom_range(0, 40), 1'b0);
		end
		chk(32'(missed), 32'h0);
		av(1'b0, REG_STATUS, 32'h0);
		chk(32'(rd[ST_SEQ_ERR]), 32'h0);
		frag(6'h03, 1'b0, FRAG_START, 1'b1, 249, 1'b0);
		chk(32'(missed), 32'h1);
		av(1'b0, REG_MISSED, 32'h0);
		chk(32'(rd[5:0]), 32'h2);
		av(1'b1, REG_STATUS, 32'h2);
		av(1'b1, REG_LIMIT, 32'h4);
		chk(32'(missed), 32'h0);
		// Lowered limit: 4 wraps straight to 0
		frag(6'h04, 1'b0, FRAG_START, 1'b1, 5, 1'b0);
		frag(6'h00, 1'b0, FRAG_START, 1'b1, 5, 1'b0);
		chk(32'(missed), 32'h0);
		// Unnumbered messages must not disturb tracking
		for (int i = 0; i < 4; i++) begin
			frag(6'($urandom_range(5, 63)), 1'b0, FRAG_START, 1'b0, 1 + $urandom_range(0, 30), 1'b0);
		end
		frag(6'h01, 1'b0, FRAG_START, 1'b1, 3, 1'b0);
		chk(32'(missed), 32'h0);
		// Frozen clock enable: a whole numbered fragment must leave no trace
		clk_en <= 1'b0;
		d_frz = d_cnt;
		enc.send(6'h11, 1'b0, FRAG_START, 1'b1, 6, 1'b0);
		repeat (2) @(posedge clk_sys);
		chk(32'(d_cnt - d_frz), 32'h0);
		chk(32'(got_q.size()), 32'h0);
		enc.exp_q.delete();
		clk_en <= 1'b1;
		chk(32'(missed), 32'h0);
		// Wrong fragment number after a start fragment, then resync clears it
		frag(6'h05, 1'b1, FRAG_START, 1'b0, 3, 1'b0);
		frag(6'h05, 1'b0, 2'h1, 1'b0, 3, 1'b0);
		av(1'b0, REG_STATUS, 32'h0);
		chk(32'(rd[ST_SEQ_ERR]), 32'h1);
		av(1'b1, REG_CTRL, 32'h3);
		av(1'b0, REG_STATUS, 32'h0);
		chk(32'(rd[ST_SEQ_ERR]), 32'h0);
		tally_and_finish();
	end
endmodule : psm_header_bench
